/* File: rtl/fmba_pkg.sv */
// Package with constants and types for the four-master bus arbiter
package fmba_pkg;
	// Number of chip-select pins
	localparam int unsigned FMBA_NUM_CS = 8;
	// Number of upper address pins that can be switched to general I/O
	localparam int unsigned FMBA_NUM_UPPER_ADDR = 3;
	// Number of consecutive high samples that end the release
	localparam logic [1:0] FMBA_REL_END_SAMPLES = 2'h2;
	// Least number of states from request low to release
	localparam logic [1:0] FMBA_REL_MIN_STATES = 2'h2;
	// Grant states, one-hot
	typedef enum logic [3:0] {
		FMBA_OWN_CPU = 4'h1,
		FMBA_OWN_DMA = 4'h2,
		FMBA_OWN_RFSH = 4'h4,
		FMBA_OWN_EXT = 4'h8
	} fmba_owner_e;
endpackage

/* File: rtl/fmba_sync.sv */
// Three-flop input synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
module fmba_sync #(
	parameter logic RESET_VAL = 1'b1
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic async_in,
	output logic sync_out
);
	logic s1_q;
	logic s2_q;
	logic s3_q;
	logic out_q;
	logic out_d;
	// Accept a new level once second and third stages agree
	always_comb begin
		out_d = out_q;
		if (s2_q == s3_q) begin
			out_d = s2_q;
		end
	end
	// Register the chain and the filtered level
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s1_q <= RESET_VAL;
			s2_q <= RESET_VAL;
			s3_q <= RESET_VAL;
			out_q <= RESET_VAL;
		end else begin
			s1_q <= async_in;
			s2_q <= s1_q;
			s3_q <= s2_q;
			out_q <= out_d;
		end
	end
	assign sync_out = out_q;
endmodule
`default_nettype wire

/* File: rtl/fmba_arbiter.sv */
// Fixed-priority arbiter for external, refresh, DMA and CPU bus masters
//
// Contract
// - Priority: external, refresh, DMA, then CPU
// - Acknowledge only top requester; owner keeps bus
// - Evaluate always, hand over at release points
// - CPU yields at cycle boundary, not mid-word
// - CPU internal work: hand over at once
// - CPU sleeping: hand over at once
// - DMA yields after full read-write transfer or once its request drops
// - Refresh holds bus until refresh cycle completes or its request drops
// - External release only while release enable set
// - External master holds request low while owning
// - Released: float pins, selects high, acknowledge low
// - Sample request on rising edge, release later
// - Two high samples end the release
// - At least two states from request to release
// - Width, state, wait writes apply next cycle
// - Select direction writes apply from third state
// - Upper address switch applies from third state
`timescale 1ns/1ps
`default_nettype none
module fmba_arbiter
	import fmba_pkg::*;
#(
	parameter int unsigned NUM_CS = fmba_pkg::FMBA_NUM_CS,
	parameter int unsigned NUM_UA = fmba_pkg::FMBA_NUM_UPPER_ADDR
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic ext_bus_request_n,
	input wire logic ext_release_enable,
	input wire logic rfsh_req,
	input wire logic rfsh_cycle_done,
	input wire logic dma_req,
	input wire logic dma_xfer_done,
	input wire logic cpu_cycle_end,
	input wire logic cpu_word_first_half,
	input wire logic cpu_internal_op,
	input wire logic cpu_sleep,
	input wire logic bus_state_t3,
	input wire logic cfg_write,
	input wire logic [7:0] bus_width_ctrl_wr,
	input wire logic [7:0] access_state_ctrl_wr,
	input wire logic [7:0] wait_enable_wr,
	input wire logic cs_ddr_write,
	input wire logic [NUM_CS-1:0] cs_ddr_wr,
	input wire logic ua_ctrl_write,
	input wire logic [NUM_UA-1:0] ua_ctrl_wr,
	input wire logic addr_strobe_n_int,
	input wire logic upper_write_n_int,
	input wire logic lower_write_n_int,
	input wire logic read_n_int,
	input wire logic [NUM_CS-1:0] chip_select_n_int,
	output logic ext_bus_ack_n,
	output logic cpu_ack,
	output logic dma_ack,
	output logic rfsh_ack,
	output logic bus_drive_en,
	output logic addr_strobe_n,
	output logic upper_write_n,
	output logic lower_write_n,
	output logic read_n,
	output logic [NUM_CS-1:0] chip_select_n,
	output logic [NUM_CS-1:0] cs_pin_is_select,
	output logic [NUM_UA-1:0] ua_pin_is_addr,
	output logic [7:0] bus_width_ctrl_reg,
	output logic [7:0] access_state_ctrl_reg,
	output logic [7:0] wait_enable_reg
);
	import fmba_pkg::*;

	// ************************************************************
	// Request sampling
	// ************************************************************
	logic ext_req_n_s;
	// Pin request crosses in through three flops
	// sampled on rising edge
	fmba_sync #(
		.RESET_VAL(1'b1)
	) u_req_sync (
		.clk(clk),
		.rst_n(rst_n),
		.async_in(ext_bus_request_n),
		.sync_out(ext_req_n_s)
	);

	// Highest-priority requester as one-hot
	function automatic fmba_owner_e fmba_pick(input logic ext, input logic rf, input logic dm);
		fmba_owner_e w;
		if (ext) begin
			w = FMBA_OWN_EXT;
		end else if (rf) begin
			w = FMBA_OWN_RFSH;
		end else if (dm) begin
			w = FMBA_OWN_DMA;
		end else begin
			w = FMBA_OWN_CPU;
		end
		return w;
	endfunction

	// ************************************************************
	// Ownership state
	// ************************************************************
	fmba_owner_e own_q, own_d;
	logic [1:0] low_cnt_q, low_cnt_d;
	logic [1:0] high_cnt_q, high_cnt_d;
	logic ext_want;
	logic release_pt;
	fmba_owner_e winner;

	// Work out request, release point and next owner
	always_comb begin
		// request low for two states first
		ext_want = !ext_req_n_s && ext_release_enable && (low_cnt_q >= FMBA_REL_MIN_STATES);
		winner = fmba_pick(ext_want, rfsh_req, dma_req);
		release_pt = 1'b0;
		own_d = own_q;
		low_cnt_d = ext_req_n_s ? 2'h0 : low_cnt_q;
		high_cnt_d = ext_req_n_s ? high_cnt_q : 2'h0;
		if (!ext_req_n_s && low_cnt_q != '1) begin
			low_cnt_d = low_cnt_q + 2'h1;
		end
		if (ext_req_n_s && high_cnt_q != '1) begin
			high_cnt_d = high_cnt_q + 2'h1;
		end
		case (own_q)
			FMBA_OWN_CPU: begin
				release_pt = (cpu_cycle_end && !cpu_word_first_half) || cpu_internal_op || cpu_sleep;
			end
			FMBA_OWN_DMA: begin
				// whole transfer done, or request gone
				release_pt = dma_xfer_done || !dma_req;
			end
			FMBA_OWN_RFSH: begin
				release_pt = rfsh_cycle_done || !rfsh_req;
			end
			FMBA_OWN_EXT: begin
				release_pt = (high_cnt_q >= FMBA_REL_END_SAMPLES);
				if (release_pt) begin
					winner = fmba_pick(1'b0, rfsh_req, dma_req);
				end
			end
			default: begin
				release_pt = 1'b1;
			end
		endcase
		// hand over only at release points
		// single owner changes at a point
		if (release_pt && winner != own_q) begin
			own_d = winner;
		end
	end

	// Register ownership and request counters
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			own_q <= FMBA_OWN_CPU;
			low_cnt_q <= 2'h0;
			high_cnt_q <= 2'h0;
		end else begin
			own_q <= own_d;
			low_cnt_q <= low_cnt_d;
			high_cnt_q <= high_cnt_d;
		end
	end

	// ************************************************************
	// Acknowledges and pin control
	// ************************************************************
	logic rel_d;
	logic [3:0] ack_d, ack_q;
	logic [NUM_CS-1:0] cs_d, cs_q;
	logic [3:0] ctl_d, ctl_q;
	logic drv_d, drv_q;

	// released: float, selects high, ack low
	always_comb begin
		rel_d = (own_d == FMBA_OWN_EXT);
		ack_d = own_d;
		// Top bit holds the active-low pin level so the pin leaves a flop
		ack_d[3] = !rel_d;
		drv_d = !rel_d;
		cs_d = rel_d ? {NUM_CS{1'b1}} : chip_select_n_int;
		ctl_d = rel_d ? 4'hf : {addr_strobe_n_int, upper_write_n_int, lower_write_n_int,
			read_n_int};
	end

	// Register acknowledges and strobes
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			// CPU owns the bus, acknowledge pin idles high
			ack_q <= FMBA_OWN_CPU | FMBA_OWN_EXT;
			drv_q <= 1'b1;
			cs_q <= {NUM_CS{1'b1}};
			ctl_q <= 4'hf;
		end else begin
			ack_q <= ack_d;
			drv_q <= drv_d;
			cs_q <= cs_d;
			ctl_q <= ctl_d;
		end
	end

	assign cpu_ack = ack_q[0];
	assign dma_ack = ack_q[1];
	assign rfsh_ack = ack_q[2];
	assign ext_bus_ack_n = ack_q[3];
	assign bus_drive_en = drv_q;
	assign addr_strobe_n = ctl_q[3];
	assign upper_write_n = ctl_q[2];
	assign lower_write_n = ctl_q[1];
	assign read_n = ctl_q[0];
	assign chip_select_n = cs_q;

	// ************************************************************
	// Configuration write timing
	// ************************************************************
	logic [7:0] bw_pend_q, bw_pend_d, bw_q, bw_d;
	logic [7:0] as_pend_q, as_pend_d, as_q, as_d;
	logic [7:0] we_pend_q, we_pend_d, we_q, we_d;
	logic pend_q, pend_d;
	logic [NUM_CS-1:0] csdir_pend_q, csdir_pend_d, csdir_q, csdir_d;
	logic csdir_wait_q, csdir_wait_d;
	logic [NUM_UA-1:0] ua_pend_q, ua_pend_d, ua_q, ua_d;
	logic ua_wait_q, ua_wait_d;

	// Hold writes and apply them at the proper point
	always_comb begin
		bw_pend_d = bw_pend_q;
		as_pend_d = as_pend_q;
		we_pend_d = we_pend_q;
		pend_d = pend_q;
		bw_d = bw_q;
		as_d = as_q;
		we_d = we_q;
		if (pend_q && cpu_cycle_end) begin
			bw_d = bw_pend_q;
			as_d = as_pend_q;
			we_d = we_pend_q;
			pend_d = 1'b0;
		end
		if (cfg_write) begin
			bw_pend_d = bus_width_ctrl_wr;
			as_pend_d = access_state_ctrl_wr;
			we_pend_d = wait_enable_wr;
			pend_d = 1'b1;
		end
		csdir_pend_d = cs_ddr_write ? cs_ddr_wr : csdir_pend_q;
		csdir_wait_d = cs_ddr_write || csdir_wait_q;
		csdir_d = csdir_q;
		if ((cs_ddr_write || csdir_wait_q) && bus_state_t3) begin
			csdir_d = cs_ddr_write ? cs_ddr_wr : csdir_pend_q;
			csdir_wait_d = 1'b0;
		end
		ua_pend_d = ua_ctrl_write ? ua_ctrl_wr : ua_pend_q;
		ua_wait_d = ua_ctrl_write || ua_wait_q;
		ua_d = ua_q;
		if ((ua_ctrl_write || ua_wait_q) && bus_state_t3) begin
			ua_d = ua_ctrl_write ? ua_ctrl_wr : ua_pend_q;
			ua_wait_d = 1'b0;
		end
	end

	// Register configuration state
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			bw_pend_q <= 8'hff;
			as_pend_q <= 8'hff;
			we_pend_q <= 8'hff;
			bw_q <= 8'hff;
			as_q <= 8'hff;
			we_q <= 8'hff;
			pend_q <= 1'b0;
			csdir_pend_q <= '0;
			csdir_q <= '0;
			csdir_wait_q <= 1'b0;
			ua_pend_q <= '0;
			ua_q <= '0;
			ua_wait_q <= 1'b0;
		end else begin
			bw_pend_q <= bw_pend_d;
			as_pend_q <= as_pend_d;
			we_pend_q <= we_pend_d;
			bw_q <= bw_d;
			as_q <= as_d;
			we_q <= we_d;
			pend_q <= pend_d;
			csdir_pend_q <= csdir_pend_d;
			csdir_q <= csdir_d;
			csdir_wait_q <= csdir_wait_d;
			ua_pend_q <= ua_pend_d;
			ua_q <= ua_d;
			ua_wait_q <= ua_wait_d;
		end
	end

	assign bus_width_ctrl_reg = bw_q;
	assign access_state_ctrl_reg = as_q;
	assign wait_enable_reg = we_q;
	assign cs_pin_is_select = csdir_q;
	assign ua_pin_is_addr = ua_q;
endmodule
`default_nettype wire

/* File: verif/fmba_ext_master.sv */
// Model of the external bus master on the request pin
`timescale 1ns/1ps
`default_nettype none
module fmba_ext_master (
	input wire logic clk,
	input wire logic go,
	input wire logic ext_bus_ack_n,
	output logic ext_bus_request_n
);
	// Request on go, hold until granted, then release and stay high
	initial begin
		ext_bus_request_n = 1'b1;
		forever begin
			// Look at go on the rising edge, away from the edge that drives it
			@(posedge clk);
			if (go) begin
				@(negedge clk);
				ext_bus_request_n = 1'b0;
				wait (ext_bus_ack_n === 1'b0);
				repeat (4) @(negedge clk);
				ext_bus_request_n = 1'b1;
				repeat (4) @(negedge clk);
			end
		end
	end
endmodule
`default_nettype wire

/* File: verif/fmba_arbiter_assertions.sv */
// Port-level checks on the bus arbiter
`timescale 1ns/1ps
`default_nettype none
module fmba_arbiter_assertions #(
	parameter int unsigned NUM_CS = 8
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic ext_bus_request_n,
	input wire logic ext_release_enable,
	input wire logic rfsh_req,
	input wire logic rfsh_cycle_done,
	input wire logic dma_req,
	input wire logic dma_xfer_done,
	input wire logic cpu_cycle_end,
	input wire logic cpu_word_first_half,
	input wire logic cpu_internal_op,
	input wire logic cpu_sleep,
	input wire logic bus_state_t3,
	input wire logic ext_bus_ack_n,
	input wire logic cpu_ack,
	input wire logic dma_ack,
	input wire logic rfsh_ack,
	input wire logic bus_drive_en,
	input wire logic [NUM_CS-1:0] chip_select_n,
	input wire logic [NUM_CS-1:0] cs_pin_is_select,
	input wire logic [7:0] bus_width_ctrl_reg
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	AST_ONE_OWNER: assert property ($onehot({!ext_bus_ack_n, rfsh_ack, dma_ack, cpu_ack}))
		else $error("owner not one-hot");
	AST_REL_PINS: assert property (!ext_bus_ack_n |-> !bus_drive_en && &chip_select_n)
		else $error("pins driven while released");
	AST_NO_EN: assert property ($fell(ext_bus_ack_n) |-> $past(ext_release_enable))
		else $error("released without enable");
	AST_REQ_DELAY: assert property ($fell(ext_bus_ack_n) |-> !$past(ext_bus_request_n, 2))
		else $error("release too soon after request");
	AST_EXT_END: assert property ($rose(ext_bus_ack_n) |-> $past(ext_bus_request_n, 2))
		else $error("release ended on one sample");
	AST_CPU_POINT: assert property ($fell(cpu_ack) |-> $past((cpu_cycle_end &&
		!cpu_word_first_half) || cpu_internal_op || cpu_sleep)) else $error("cpu lost bus early");
	AST_DMA_POINT: assert property ($fell(dma_ack) |-> $past(dma_xfer_done || !dma_req))
		else $error("dma lost bus mid transfer");
	AST_RFSH_POINT: assert property ($fell(rfsh_ack) |-> $past(rfsh_cycle_done || !rfsh_req))
		else $error("refresh lost bus early");
	AST_CFG_NEXT: assert property ($changed(bus_width_ctrl_reg) |-> $past(cpu_cycle_end))
		else $error("width setting changed mid cycle");
	AST_DDR_T3: assert property ($changed(cs_pin_is_select) |-> $past(bus_state_t3))
		else $error("select function changed off third state");
	cover property ($fell(ext_bus_ack_n));
	cover property ($fell(dma_ack) && rfsh_req);
	cover property ($fell(rfsh_ack));
endmodule
bind fmba_arbiter fmba_arbiter_assertions #(.NUM_CS(NUM_CS)) chk_u (.clk, .rst_n,
	.ext_bus_request_n, .ext_release_enable, .rfsh_req, .rfsh_cycle_done, .dma_req,
	.dma_xfer_done, .cpu_cycle_end, .cpu_word_first_half, .cpu_internal_op, .cpu_sleep,
	.bus_state_t3, .ext_bus_ack_n, .cpu_ack, .dma_ack, .rfsh_ack, .bus_drive_en,
	.chip_select_n, .cs_pin_is_select, .bus_width_ctrl_reg);
`default_nettype wire

/* File: verif/four_master_bus_arbiter_tb.sv */
// Self-checking bench for the bus arbiter
`timescale 1ns/1ps
`default_nettype none
module four_master_bus_arbiter_tb;
	import fmba_pkg::*;
	logic clk = 1'b0, rst_n = 1'b0, go = 1'b0, ext_release_enable = 1'b0;
	logic rfsh_req = 1'b0, rfsh_cycle_done = 1'b0, dma_req = 1'b0, dma_xfer_done = 1'b0;
	logic cpu_cycle_end = 1'b0, cpu_word_first_half = 1'b0, cpu_internal_op = 1'b0;
	logic cpu_sleep = 1'b0, bus_state_t3 = 1'b0, cfg_write = 1'b0, cs_ddr_write = 1'b0;
	logic ua_ctrl_write = 1'b0, addr_strobe_n_int = 1'b0, upper_write_n_int = 1'b0;
	logic lower_write_n_int = 1'b0, read_n_int = 1'b0, ext_bus_request_n;
	logic [7:0] bus_width_ctrl_wr = 8'h00, access_state_ctrl_wr = 8'h00;
	logic [7:0] wait_enable_wr = 8'h00, cs_ddr_wr = 8'h00, chip_select_n_int = 8'h00;
	logic [2:0] ua_ctrl_wr = 3'h0, ua_pin_is_addr;
	logic ext_bus_ack_n, cpu_ack, dma_ack, rfsh_ack, bus_drive_en;
	logic addr_strobe_n, upper_write_n, lower_write_n, read_n;
	logic [7:0] chip_select_n, cs_pin_is_select, bus_width_ctrl_reg;
	logic [7:0] access_state_ctrl_reg, wait_enable_reg;
	int n_fail = 0, cmp_count = 0;
	wire [3:0] own = {!ext_bus_ack_n, rfsh_ack, dma_ack, cpu_ack};
	// Clock of 8 ns
	always #4 clk = ~clk;
	fmba_arbiter dut_u (.clk, .rst_n, .ext_bus_request_n, .ext_release_enable, .rfsh_req,
		.rfsh_cycle_done, .dma_req, .dma_xfer_done, .cpu_cycle_end, .cpu_word_first_half,
		.cpu_internal_op, .cpu_sleep, .bus_state_t3, .cfg_write, .bus_width_ctrl_wr,
		.access_state_ctrl_wr, .wait_enable_wr, .cs_ddr_write, .cs_ddr_wr, .ua_ctrl_write,
		.ua_ctrl_wr, .addr_strobe_n_int, .upper_write_n_int, .lower_write_n_int, .read_n_int,
		.chip_select_n_int, .ext_bus_ack_n, .cpu_ack, .dma_ack, .rfsh_ack, .bus_drive_en,
		.addr_strobe_n, .upper_write_n, .lower_write_n, .read_n, .chip_select_n,
		.cs_pin_is_select, .ua_pin_is_addr, .bus_width_ctrl_reg, .access_state_ctrl_reg,
		.wait_enable_reg);
	fmba_ext_master ext_u (.clk, .go, .ext_bus_ack_n, .ext_bus_request_n);
	// Compare and count
	task automatic chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
		cmp_count++;
		if (got !== exp) begin
			n_fail++;
			$display("[ERR] %s expected %h seen %h", nm, exp, got);
		end
	endtask
	// Bounded wait for an owner
	task automatic wait_own(input logic [3:0] exp);
		for (int i = 0; i < 40 && own !== exp; i++) @(negedge clk);
		chk("owner", own, exp);
	endtask
	task automatic end_of_test;
		$display("comparisons %0d mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	// Idle values and select pass-through
	task automatic t_reset;
		chk("owner", own, FMBA_OWN_CPU);
		chk("width", bus_width_ctrl_reg, 8'hff);
		chip_select_n_int = 8'h5a;
		{addr_strobe_n_int, upper_write_n_int, lower_write_n_int, read_n_int} = 4'ha;
		repeat (2) @(negedge clk);
		chk("cs", chip_select_n, 8'h5a);
		chk("strobes", {addr_strobe_n, upper_write_n, lower_write_n, read_n}, 8'h0a);
		chk("drive", bus_drive_en, 8'h01);
	endtask
	// External first, then refresh, DMA and CPU in turn
	task automatic t_ext_prio;
		ext_release_enable = 1'b1;
		cpu_internal_op = 1'b1;
		go = 1'b1;
		@(negedge clk) go = 1'b0;
		wait_own(FMBA_OWN_EXT);
		chk("cs", chip_select_n, 8'hff);
		chk("strobes", {addr_strobe_n, upper_write_n, lower_write_n, read_n}, 8'h0f);
		chk("drive", bus_drive_en, 8'h00);
		rfsh_req = 1'b1;
		dma_req = 1'b1;
		repeat (2) @(negedge clk);
		chk("owner", own, FMBA_OWN_EXT);
		wait_own(FMBA_OWN_RFSH);
		rfsh_cycle_done = 1'b1;
		rfsh_req = 1'b0;
		@(negedge clk) rfsh_cycle_done = 1'b0;
		wait_own(FMBA_OWN_DMA);
		dma_xfer_done = 1'b1;
		dma_req = 1'b0;
		@(negedge clk) dma_xfer_done = 1'b0;
		wait_own(FMBA_OWN_CPU);
		cpu_internal_op = 1'b0;
	endtask
	// Split word, then DMA held until its transfer ends
	task automatic t_midword;
		dma_req = 1'b1;
		cpu_word_first_half = 1'b1;
		cpu_cycle_end = 1'b1;
		@(negedge clk) cpu_cycle_end = 1'b0;
		repeat (3) @(negedge clk);
		chk("owner", own, FMBA_OWN_CPU);
		cpu_word_first_half = 1'b0;
		cpu_cycle_end = 1'b1;
		@(negedge clk) cpu_cycle_end = 1'b0;
		wait_own(FMBA_OWN_DMA);
		rfsh_req = 1'b1;
		repeat (3) @(negedge clk);
		chk("owner", own, FMBA_OWN_DMA);
		dma_xfer_done = 1'b1;
		@(negedge clk) dma_xfer_done = 1'b0;
		wait_own(FMBA_OWN_RFSH);
		rfsh_cycle_done = 1'b1;
		rfsh_req = 1'b0;
		@(negedge clk) rfsh_cycle_done = 1'b0;
		wait_own(FMBA_OWN_DMA);
		dma_req = 1'b0;
		wait_own(FMBA_OWN_CPU);
	endtask
	// Request refused while disabled, granted in sleep
	task automatic t_refused;
		ext_release_enable = 1'b0;
		cpu_sleep = 1'b1;
		go = 1'b1;
		@(negedge clk) go = 1'b0;
		repeat (20) @(negedge clk);
		chk("owner", own, FMBA_OWN_CPU);
		ext_release_enable = 1'b1;
		wait_own(FMBA_OWN_EXT);
		wait_own(FMBA_OWN_CPU);
		cpu_sleep = 1'b0;
	endtask
	// Setting writes and pin-function writes
	task automatic t_regs;
		bus_width_ctrl_wr = 8'h12;
		access_state_ctrl_wr = 8'h34;
		wait_enable_wr = 8'h56;
		cs_ddr_wr = 8'h02;
		ua_ctrl_wr = 3'h5;
		cfg_write = 1'b1;
		cs_ddr_write = 1'b1;
		ua_ctrl_write = 1'b1;
		@(negedge clk);
		cfg_write = 1'b0;
		cs_ddr_write = 1'b0;
		ua_ctrl_write = 1'b0;
		repeat (3) @(negedge clk);
		chk("width", bus_width_ctrl_reg, 8'hff);
		chk("cs_fn", cs_pin_is_select, 8'h00);
		chk("ua_fn", ua_pin_is_addr, 3'h0);
		cpu_cycle_end = 1'b1;
		bus_state_t3 = 1'b1;
		@(negedge clk);
		cpu_cycle_end = 1'b0;
		bus_state_t3 = 1'b0;
		@(negedge clk);
		chk("width", bus_width_ctrl_reg, 8'h12);
		chk("state", access_state_ctrl_reg, 8'h34);
		chk("wait", wait_enable_reg, 8'h56);
		chk("cs_fn", cs_pin_is_select, 8'h02);
		chk("ua_fn", ua_pin_is_addr, 3'h5);
	endtask
	// Main sequence
	initial begin
		repeat (10) @(negedge clk);
		rst_n = 1'b1;
		@(negedge clk);
		t_reset();
		t_ext_prio();
		t_midword();
		t_refused();
		t_regs();
		end_of_test();
	end
	// Watchdog
	initial begin
		#40000;
		n_fail++;
		end_of_test();
	end
endmodule
`default_nettype wire
